/* bps_scheduler.sv */
// Base station poll scheduler with staged configuration
//
// Operation
// - Asymmetric: base slot after every remote slot
// - Symmetric: one base slot per polling cycle
// - Defaults select asymmetric scheduling
// - No answer within window marks remote idle
// - Idle remote skipped for level minus one polling rounds
// - Skip level accepts 1 to 100, default 1
// - Active/idle tracked per remote automatically
// - Scheduling settings only act on base
// - Pending set applied on reboot, test timed
// - Save copies running set to storage
// - Three copies: pending, running, stored
module bps_scheduler #(
    parameter longint unsigned TEST_MIN_CYC = bps_pkg::MIN_CYC
) (
    input  wire logic                     sys_clk,
    input  wire logic                     rst,
    input  wire logic [7:0]               addr,
    input  wire logic [31:0]              wr_data,
    input  wire logic                     wr_en,
    input  wire logic                     rd_en,
    output logic [31:0]                   rd_data_q,
    output logic                          poll_q,
    output logic [bps_pkg::ID_W-1:0]      poll_id_q,
    input  wire logic                     resp_valid,
    input  wire logic [bps_pkg::ID_W-1:0] resp_id,
    output logic                          base_slot_q,
    output logic                          test_active_q
);

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    logic [31:0]                new_q;       // Pending settings
    logic [31:0]                cur_q;       // Running settings
    logic [31:0]                flash_q;     // Stored settings
    logic                       wr_new;      // Write to pending word
    logic                       wr_cmd;      // Write to command word
    logic                       reboot;      // Apply pending settings
    logic                       save;        // Store running settings
    logic                       expire;      // Test period ran out
    logic                       sched_clr;   // Running settings changed
    logic [bps_pkg::LVL_W-1:0]  wr_lvl;      // Level being written
    logic [bps_pkg::MIN_W-1:0]  wr_min;      // Minutes being written
    logic                       cur_base;    // Running as base station
    logic                       cur_sym;     // Running symmetric
    logic [bps_pkg::LVL_W-1:0]  cur_lvl;     // Running skip level
    bps_pkg::bps_state_t        st_q;        // Scheduler state
    logic [bps_pkg::ID_W-1:0]   ptr_q;       // Remote under service
    logic [bps_pkg::CNT_W-1:0]  win_q;       // Window or slot counter
    logic                       round_tick_q;// Polling round finished
    logic                       resp_hit;    // Expected answer arrived
    logic                       timeout;     // Window closed unanswered
    logic                       last;        // Pointer at final remote
    logic                       slot_end;    // Remote slot finishing
    logic [bps_pkg::NUM_REM-1:0] idle_vec;   // Idle flag per remote
    logic [bps_pkg::NUM_REM-1:0] elig_vec;   // May be polled this round

    ////////////////////////////////////////////////////////////////////////
    // Bus decode
    assign wr_new = wr_en && addr == bps_pkg::A_NEW;
    assign wr_cmd = wr_en && addr == bps_pkg::A_CMD;
    assign reboot = wr_cmd && wr_data[bps_pkg::C_REBOOT];
    assign save   = wr_cmd && wr_data[bps_pkg::C_SAVE];
    assign wr_lvl = wr_data[bps_pkg::F_LVL +: bps_pkg::LVL_W];
    assign wr_min = wr_data[bps_pkg::F_MIN +: bps_pkg::MIN_W];

    // Any change of the running set restarts polling from scratch
    assign sched_clr = reboot || expire;

    // Running fields
    assign cur_base = cur_q[bps_pkg::F_BASE];
    assign cur_sym  = cur_q[bps_pkg::F_SYM];
    assign cur_lvl  = cur_q[bps_pkg::F_LVL +: bps_pkg::LVL_W];

    ////////////////////////////////////////////////////////////////////////
    // Pending settings; out-of-range numbers leave the old field alone
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            new_q <= bps_pkg::RST_CFG;
        end else if (wr_new) begin
            new_q[bps_pkg::F_BASE] <= wr_data[bps_pkg::F_BASE];
            new_q[bps_pkg::F_SYM]  <= wr_data[bps_pkg::F_SYM];
            // Level range 1..100
            if (wr_lvl >= bps_pkg::LVL_LO && wr_lvl <= bps_pkg::LVL_HI) begin
                new_q[bps_pkg::F_LVL +: bps_pkg::LVL_W] <= wr_lvl;
            end
            // Test minutes range 1..120
            if (wr_min >= bps_pkg::MIN_LO && wr_min <= bps_pkg::MIN_HI) begin
                new_q[bps_pkg::F_MIN +: bps_pkg::MIN_W] <= wr_min;
            end
        end
    end

    // Running settings: reboot takes pending, expiry takes stored
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            cur_q <= bps_pkg::RST_CFG;
        end else if (reboot) begin
            cur_q <= new_q;
        end else if (expire) begin
            cur_q <= flash_q;
        end
    end

    // Stored settings; flops stand in for non-volatile memory, so a
    // reset here returns the factory set, unlike real flash
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            flash_q <= bps_pkg::RST_CFG;
        end else if (save) begin
            flash_q <= cur_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Test period timer; a save ends the test and keeps the running set
    bps_test_timer #(
        .MIN_CYC (TEST_MIN_CYC)
    ) u_timer (
        .sys_clk  (sys_clk),
        .rst      (rst),
        .start    (reboot),
        .stop     (save),
        .minutes  (new_q[bps_pkg::F_MIN +: bps_pkg::MIN_W]),
        .active_q (test_active_q),
        .expire_q (expire)
    );

    ////////////////////////////////////////////////////////////////////////
    // Slot bookkeeping
    assign resp_hit = st_q == bps_pkg::ST_WAIT && resp_valid && resp_id == ptr_q;
    assign timeout  = st_q == bps_pkg::ST_WAIT && !resp_hit &&
                      win_q == bps_pkg::RESP_LAST;
    assign last     = ptr_q == 3'(bps_pkg::NUM_REM - 1);
    assign slot_end = resp_hit || timeout;

    // One tracker per remote
    for (genvar g = 0; g < bps_pkg::NUM_REM; g++) begin : g_trk
        bps_remote_track u_trk (
            .sys_clk    (sys_clk),
            .rst        (rst),
            .clear      (sched_clr),
            .round_tick (round_tick_q),
            .level      (cur_lvl),
            .mark_idle  (timeout && ptr_q == 3'(g)),
            .mark_act   (resp_hit && ptr_q == 3'(g)),
            .idle_q     (idle_vec[g]),
            .eligible   (elig_vec[g])
        );
    end

    ////////////////////////////////////////////////////////////////////////
    // Scheduler state machine
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            st_q         <= bps_pkg::ST_OFF;
            ptr_q        <= '0;
            win_q        <= '0;
            poll_q       <= 1'b0;
            poll_id_q    <= '0;
            base_slot_q  <= 1'b0;
            round_tick_q <= 1'b0;
        end else begin
            poll_q       <= 1'b0;
            round_tick_q <= 1'b0;
            if (sched_clr) begin
                // New running set: start a fresh polling cycle
                st_q        <= bps_pkg::ST_OFF;
                ptr_q       <= '0;
                win_q       <= '0;
                base_slot_q <= 1'b0;
            end else begin
                unique case (st_q)
                    // Remote units never poll
                    bps_pkg::ST_OFF: begin
                        if (cur_base) begin
                            st_q <= bps_pkg::ST_PICK;
                        end
                    end
                    // Poll the remote or pass over it
                    bps_pkg::ST_PICK: begin
                        if (!cur_base) begin
                            st_q <= bps_pkg::ST_OFF;
                        end else if (elig_vec[ptr_q]) begin
                            poll_q    <= 1'b1;
                            poll_id_q <= ptr_q;
                            win_q     <= '0;
                            st_q      <= bps_pkg::ST_WAIT;
                        end else begin
                            ptr_q        <= ptr_q + 3'h1;
                            round_tick_q <= last;
                            // Skipped remotes get no slot, but a symmetric
                            // cycle still ends with the base slot
                            if (last && cur_sym) begin
                                st_q        <= bps_pkg::ST_BASE;
                                base_slot_q <= 1'b1;
                                win_q       <= '0;
                            end
                        end
                    end
                    // Response window
                    bps_pkg::ST_WAIT: begin
                        if (slot_end) begin
                            ptr_q        <= ptr_q + 3'h1;
                            round_tick_q <= last;
                            if (!cur_sym || last) begin
                                st_q        <= bps_pkg::ST_BASE;
                                base_slot_q <= 1'b1;
                                win_q       <= '0;
                            end else begin
                                st_q <= bps_pkg::ST_PICK;
                            end
                        end else begin
                            win_q <= win_q + 9'h001;
                        end
                    end
                    // Base transmit slot of fixed length
                    bps_pkg::ST_BASE: begin
                        if (win_q == bps_pkg::BSLOT_LAST) begin
                            base_slot_q <= 1'b0;
                            st_q        <= bps_pkg::ST_PICK;
                        end else begin
                            win_q <= win_q + 9'h001;
                        end
                    end
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Register read; unmapped and write-only words read as zero
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            rd_data_q <= '0;
        end else begin
            rd_data_q <= '0;
            if (rd_en) begin
                case (addr)
                    bps_pkg::A_NEW:   rd_data_q <= new_q;
                    bps_pkg::A_CUR:   rd_data_q <= cur_q;
                    bps_pkg::A_FLASH: rd_data_q <= flash_q;
                    bps_pkg::A_STAT: begin
                        rd_data_q[bps_pkg::S_TEST]  <= test_active_q;
                        rd_data_q[bps_pkg::S_BSLOT] <= base_slot_q;
                        rd_data_q[bps_pkg::S_IDLE +: bps_pkg::NUM_REM] <= idle_vec;
                    end
                    default:          rd_data_q <= '0;
                endcase
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    localparam int RESP_WIN_LIM = 500;

    asym_base_slot_a: assert property (@(posedge sys_clk) disable iff (rst)
        slot_end && !cur_sym && !sched_clr |=> base_slot_q && st_q == bps_pkg::ST_BASE)
        else $error("Base slot missing after remote slot");

    sym_no_base_a: assert property (@(posedge sys_clk) disable iff (rst)
        slot_end && cur_sym && !last && !sched_clr |=> !base_slot_q)
        else $error("Extra base slot inside symmetric cycle");

    default_asym_a: assert property (@(posedge sys_clk) disable iff (rst)
        $fell(rst) |-> !cur_q[bps_pkg::F_SYM] && !new_q[bps_pkg::F_SYM])
        else $error("Symmetric selected after reset");

    resp_window_a: assert property (@(posedge sys_clk) disable iff (rst)
        poll_q |-> ##[1:RESP_WIN_LIM] st_q != bps_pkg::ST_WAIT)
        else $error("Response window not bounded");

    idle_mark_a: assert property (@(posedge sys_clk) disable iff (rst)
        timeout && !sched_clr |=> idle_vec[$past(ptr_q)])
        else $error("Silent remote not marked idle");

    idle_skip_a: assert property (@(posedge sys_clk) disable iff (rst)
        st_q == bps_pkg::ST_PICK && cur_base && !elig_vec[ptr_q] && !sched_clr
        |=> !poll_q && ptr_q != $past(ptr_q))
        else $error("Idle remote polled during skip");

    level_range_a: assert property (@(posedge sys_clk) disable iff (rst)
        cur_lvl >= bps_pkg::LVL_LO && cur_lvl <= bps_pkg::LVL_HI &&
        new_q[bps_pkg::F_LVL +: bps_pkg::LVL_W] >= bps_pkg::LVL_LO &&
        new_q[bps_pkg::F_LVL +: bps_pkg::LVL_W] <= bps_pkg::LVL_HI)
        else $error("Skip level out of range");

    reactivate_a: assert property (@(posedge sys_clk) disable iff (rst)
        resp_hit && !sched_clr |=> !idle_vec[$past(ptr_q)])
        else $error("Answering remote left idle");

    remote_quiet_a: assert property (@(posedge sys_clk) disable iff (rst)
        !cur_base |-> !poll_q && !base_slot_q && st_q == bps_pkg::ST_OFF)
        else $error("Remote unit is scheduling");

    reboot_apply_a: assert property (@(posedge sys_clk) disable iff (rst)
        reboot |=> cur_q == $past(new_q) && test_active_q)
        else $error("Reboot did not apply pending set");

    save_store_a: assert property (@(posedge sys_clk) disable iff (rst)
        save && !reboot |=> flash_q == $past(cur_q) && !test_active_q)
        else $error("Save did not store running set");

    revert_a: assert property (@(posedge sys_clk) disable iff (rst)
        expire && !reboot |=> cur_q == $past(flash_q))
        else $error("Expiry did not revert settings");

    // Main scenarios
    asym_slot_c: cover property (@(posedge sys_clk) disable iff (rst)
        resp_hit && !cur_sym ##1 base_slot_q);
    sym_cycle_c: cover property (@(posedge sys_clk) disable iff (rst)
        slot_end && cur_sym && last ##1 base_slot_q);
    idle_back_c: cover property (@(posedge sys_clk) disable iff (rst)
        timeout ##[1:1000] resp_hit);
    revert_c: cover property (@(posedge sys_clk) disable iff (rst)
        expire);

endmodule

/* bps_pkg.sv */
// Constants, register map and state type for the base poll scheduler
package bps_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Clock and sizes
    localparam int unsigned CLK_NS  = 8;   // 125 MHz system clock period
    localparam int unsigned NUM_REM = 8;   // Remote stations served
    localparam int unsigned ID_W    = 3;   // Remote index width
    localparam int unsigned LVL_W   = 7;   // Skip level field width
    localparam int unsigned MIN_W   = 7;   // Test minutes field width
    localparam int unsigned CNT_W   = 9;   // Window and slot counter width

    ////////////////////////////////////////////////////////////////////////
    // Register byte addresses
    localparam logic [7:0] A_NEW   = 8'h00; // Pending settings, read/write
    localparam logic [7:0] A_CUR   = 8'h04; // Running settings, read only
    localparam logic [7:0] A_FLASH = 8'h08; // Stored settings, read only
    localparam logic [7:0] A_CMD   = 8'h0c; // Commands, write only
    localparam logic [7:0] A_STAT  = 8'h10; // Status, read only

    ////////////////////////////////////////////////////////////////////////
    // Field positions
    localparam int unsigned F_BASE    = 0;  // 1: unit is the base station
    localparam int unsigned F_SYM     = 1;  // 1: symmetric scheduling
    localparam int unsigned F_LVL     = 8;  // Skip level, low bit
    localparam int unsigned F_MIN     = 16; // Test minutes, low bit
    localparam int unsigned C_REBOOT  = 0;  // Command: apply pending set
    localparam int unsigned C_SAVE    = 1;  // Command: store running set
    localparam int unsigned S_TEST    = 0;  // Status: test period running
    localparam int unsigned S_BSLOT   = 1;  // Status: base slot in progress
    localparam int unsigned S_IDLE    = 8;  // Status: idle map, low bit

    ////////////////////////////////////////////////////////////////////////
    // Reset values and legal ranges
    localparam logic             RST_BASE = 1'b0;  // Remote unit by default
    localparam logic             RST_SYM  = 1'b0;  // Asymmetric by default
    localparam logic [LVL_W-1:0] RST_LVL  = 7'h01;
    localparam logic [MIN_W-1:0] RST_MIN  = 7'h1e;
    localparam logic [LVL_W-1:0] LVL_LO   = 7'h01;
    localparam logic [LVL_W-1:0] LVL_HI   = 7'h64;
    localparam logic [MIN_W-1:0] MIN_LO   = 7'h01;
    localparam logic [MIN_W-1:0] MIN_HI   = 7'h78;
    localparam logic [31:0]      RST_CFG  =
        {9'h000, RST_MIN, 1'b0, RST_LVL, 6'h00, RST_SYM, RST_BASE};

    ////////////////////////////////////////////////////////////////////////
    // Timing
    localparam int unsigned RESP_WIN_NS   = 4000; // Longest poll wait
    localparam int unsigned BASE_SLOT_NS  = 2000; // Least base slot
    localparam logic [CNT_W-1:0] RESP_LAST =
        CNT_W'(RESP_WIN_NS / CLK_NS - 1);
    localparam logic [CNT_W-1:0] BSLOT_LAST =
        CNT_W'((BASE_SLOT_NS + CLK_NS - 1) / CLK_NS - 1);
    localparam longint unsigned MINUTE_NS = 64'd60_000_000_000;
    localparam longint unsigned MIN_CYC   = MINUTE_NS / CLK_NS;

    ////////////////////////////////////////////////////////////////////////
    // Scheduler states
    typedef enum logic [1:0] {
        ST_OFF  = 2'b00,  // Not a base station, no polling
        ST_PICK = 2'b01,  // Choose next remote
        ST_WAIT = 2'b10,  // Poll sent, response window open
        ST_BASE = 2'b11   // Base station transmit slot
    } bps_state_t;

endpackage

/* bps_remote_track.sv */
// Per-remote active/idle tracker with skip round counter
module bps_remote_track (
    input  wire logic                     sys_clk,
    input  wire logic                     rst,
    input  wire logic                     clear,      // Restart, all active
    input  wire logic                     round_tick, // End of polling round
    input  wire logic [bps_pkg::LVL_W-1:0] level,     // Round ends until repoll
    input  wire logic                     mark_idle,  // No answer in window
    input  wire logic                     mark_act,   // Answer in window
    output logic                          idle_q,
    output logic                          eligible
);

    logic [bps_pkg::LVL_W-1:0] skip_q;  // Rounds still to skip

    // Idle flag and skip count; a verdict beats a round tick
    always_ff @(posedge sys_clk) begin
        if (rst || clear) begin
            idle_q <= 1'b0;
            skip_q <= '0;
        end else if (mark_idle) begin
            idle_q <= 1'b1;
            skip_q <= level;
        end else if (mark_act) begin
            idle_q <= 1'b0;
            skip_q <= '0;
        end else if (round_tick && idle_q && skip_q != '0) begin
            skip_q <= skip_q - 7'h01;
        end
    end

    // Idle remotes come back for one poll once the count runs out
    assign eligible = !idle_q || skip_q == '0;

endmodule

/* bps_test_timer.sv */
// Test period timer counting whole minutes after a reboot
module bps_test_timer #(
    parameter longint unsigned MIN_CYC = bps_pkg::MIN_CYC
) (
    input  wire logic                      sys_clk,
    input  wire logic                      rst,
    input  wire logic                      start,   // Reboot applied
    input  wire logic                      stop,    // Running set saved
    input  wire logic [bps_pkg::MIN_W-1:0] minutes, // Test length
    output logic                           active_q,
    output logic                           expire_q // One-cycle pulse
);

    logic [32:0]               pre_q;  // Cycles within the minute
    logic [bps_pkg::MIN_W-1:0] left_q; // Minutes remaining
    logic                      last_cyc;

    // Last cycle of the last minute
    assign last_cyc = active_q && pre_q == 33'(MIN_CYC - 1) && left_q == 7'h01;

    // Minute prescaler and countdown; a restart wins over everything but reset
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            active_q <= 1'b0;
            pre_q    <= '0;
            left_q   <= '0;
        end else if (start) begin
            active_q <= 1'b1;
            pre_q    <= '0;
            left_q   <= minutes;
        end else if (stop || last_cyc) begin
            active_q <= 1'b0;
            pre_q    <= '0;
        end else if (active_q) begin
            if (pre_q == 33'(MIN_CYC - 1)) begin
                pre_q  <= '0;
                left_q <= left_q - 7'h01;
            end else begin
                pre_q <= pre_q + 33'h1;
            end
        end
    end

    // Expiry pulse, suppressed by a same-cycle save or restart
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            expire_q <= 1'b0;
        end else begin
            expire_q <= last_cyc && !start && !stop;
        end
    end

endmodule

/* bps_remote_model.sv */
// Behavioural remote stations that answer base polls after a delay
module bps_remote_model (
    input  wire logic                     sys_clk,
    input  wire logic                     poll_q,
    input  wire logic [bps_pkg::ID_W-1:0] poll_id_q,
    input  wire logic [7:0]               mute,     // Remotes that stay silent
    input  wire logic [4:0]               dly,      // Answer delay in cycles
    output logic                          resp_valid,
    output logic [bps_pkg::ID_W-1:0]      resp_id
);
    timeunit 1ns;
    timeprecision 1ps;
    int                      cnt;  // Cycles left to the answer
    logic [bps_pkg::ID_W-1:0] id;  // Remote being answered for
    initial begin
        resp_valid = 1'b0;
        resp_id = '0;
        cnt = 0;
        id = '0;
    end
    // One answer per poll to an unmuted remote; the id lines wander when no answer is on them
    always @(posedge sys_clk) begin
        resp_valid <= 1'b0;
        resp_id <= ~resp_id;
        if (poll_q && !mute[poll_id_q]) begin
            cnt <= int'(dly) + 1;
            id <= poll_id_q;
        end else if (cnt == 1) begin
            resp_valid <= 1'b1;
            resp_id <= id;
            cnt <= 0;
        end else if (cnt > 1) begin
            cnt <= cnt - 1;
        end
    end
endmodule

/* testbench.sv */
// Self-checking bench for the base poll scheduler
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam longint unsigned TMC = 500; // Shortened minute keeps the run brief
    logic sys_clk, rst, wr_en, rd_en, resp_valid, poll_q, base_slot_q, test_active_q;
    logic [7:0] addr, mute;
    logic [31:0] wr_data, rd_data_q;
    logic [2:0] poll_id_q, resp_id;
    logic [4:0] dly;
    int err_count, samples_checked, nw, cu, fl, pend, lid, np, sym, mon, bprev, n0;
    int unsigned rs = 59510;
    bps_scheduler #(.TEST_MIN_CYC(TMC)) uut (.sys_clk(sys_clk), .rst(rst), .addr(addr),
        .wr_data(wr_data), .wr_en(wr_en), .rd_en(rd_en), .rd_data_q(rd_data_q),
        .poll_q(poll_q), .poll_id_q(poll_id_q), .resp_valid(resp_valid),
        .resp_id(resp_id), .base_slot_q(base_slot_q), .test_active_q(test_active_q));
    bps_remote_model rm (.sys_clk(sys_clk), .poll_q(poll_q), .poll_id_q(poll_id_q),
        .mute(mute), .dly(dly), .resp_valid(resp_valid), .resp_id(resp_id));
    function automatic int unsigned rnd();
        rs ^= rs << 13;
        rs ^= rs >> 17;
        rs ^= rs << 5;
        return rs;
    endfunction
    // Out-of-range level or minutes keep their old value
    function automatic int merge(int o, int d);
        int l;
        int m;
        l = (d >> 8) & 127;
        m = (d >> 16) & 127;
        return (d & 3) | (((l >= 1 && l <= 100) ? d : o) & 'h7f00)
            | (((m >= 1 && m <= 120) ? d : o) & 'h7f0000);
    endfunction
    task automatic chk(logic [31:0] got, int exp);
        samples_checked++;
        if (got !== exp[31:0]) begin
            err_count++;
            $display("BAD %0t got %h expected %h", $time, got, exp[31:0]);
        end
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask
    // One write cycle; the model follows pending, reboot and save
    task automatic wr(logic [7:0] a, int d);
        @(posedge sys_clk);
        addr <= a;
        wr_data <= d;
        wr_en <= 1'b1;
        if (a == bps_pkg::A_NEW) nw = merge(nw, d);
        if (a == bps_pkg::A_CMD && d[1]) fl = cu;
        if (a == bps_pkg::A_CMD && d[0]) cu = nw;
        @(posedge sys_clk);
        wr_en <= 1'b0;
    endtask
    task automatic rd(logic [7:0] a, int exp, int msk);
        @(posedge sys_clk);
        addr <= a;
        rd_en <= 1'b1;
        @(posedge sys_clk);
        rd_en <= 1'b0;
        #1 chk(rd_data_q & msk, exp);
    endtask
    initial begin
        sys_clk = 1'b0;
        forever #4 sys_clk = ~sys_clk;
    end
    // Base slots: asymmetric after any remote slot, symmetric after remote 7
    always @(posedge sys_clk) begin
        if (base_slot_q && !bprev && mon != 0) chk(sym ? lid : pend, sym ? 7 : 1);
        if (base_slot_q && !bprev) pend = 0;
        if (poll_q) begin
            pend = 1;
            lid = poll_id_q;
            np++;
        end
        bprev = base_slot_q;
    end
    initial begin
        repeat (100000) @(posedge sys_clk);
        err_count++;
        end_of_test();
    end
    initial begin
        {rst, wr_en, rd_en, mute} = 11'h400;
        {addr, wr_data, dly} = 45'h0;
        nw = bps_pkg::RST_CFG;
        {cu, fl} = {nw, nw};
        repeat (4) @(posedge sys_clk);
        rst <= 1'b0;
        for (int i = 0; i < 8; i++) rd(8'(i * 4), i < 3 ? nw : 0, -1);
        rd(8'h14, 0, -1);
        for (int i = 0; i < 4; i++) begin
            wr(bps_pkg::A_NEW, {8'h0, 8'(rnd() % 130), 8'(i * 67 % 128), 8'h0});
            rd(bps_pkg::A_NEW, nw, -1);
        end
        dly <= 5'(rnd());
        mute <= 8'h08;
        wr(bps_pkg::A_NEW, 'h640201);
        wr(bps_pkg::A_CMD, 1);
        #1 chk(test_active_q, 1);
        rd(bps_pkg::A_CUR, cu, -1);
        wr(bps_pkg::A_CMD, 2);
        rd(bps_pkg::A_FLASH, fl, -1);
        mon = 1;
        repeat (4000) @(posedge sys_clk);
        rd(bps_pkg::A_STAT, 'h800, 'h800);
        mute <= 8'h00;
        repeat (8000) @(posedge sys_clk);
        rd(bps_pkg::A_STAT, 0, 'h800);
        mon = 0;
        wr(bps_pkg::A_NEW, 'h640203);
        wr(bps_pkg::A_CMD, 3);
        mon = 1;
        sym = 1;
        repeat (4000) @(posedge sys_clk);
        mon = 0;
        sym = 0;
        wr(bps_pkg::A_NEW, 'h010100);
        wr(bps_pkg::A_CMD, 1);
        @(posedge sys_clk);
        n0 = np;
        // Silence is only owed until expiry brings the stored base set back
        repeat (int'(TMC) - 10) @(posedge sys_clk);
        chk(np, n0);
        repeat (30) @(posedge sys_clk);
        chk(test_active_q, 0);
        cu = fl;
        rd(bps_pkg::A_CUR, cu, -1);
        end_of_test();
    end
endmodule
